// File: src/bsd_top.sv
// Purpose: boundary-scan test logic: controller, bypass, boundary chain,
//          drive-control latches
// Assumes: test clock is far slower than i_clk; all test pins asynchronous
// Notes: test clock is sampled, so its edges show up four cycles late
`timescale 1ns/1ps
module bsd_top (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_tck,
    input wire logic i_tms,
    input wire logic i_tdi,
    input wire logic i_trst_n,
    input wire logic i_reset_input_pin_n,
    input wire logic [2:0] i_interrupt_level_pins,
    input wire logic [183:0] i_out_latch,
    input wire logic [183:0] i_pin_level,
    output logic o_tdo,
    output logic o_tdo_oe_n,
    output logic o_test_owns_pins,
    output logic [183:0] o_bsr_drive,
    output logic o_gen_enable,
    output logic o_ab_enable,
    output logic o_db_enable,
    output logic [2:0] o_drive_control,
    output logic o_drive_set_ready,
    output logic o_bus_wait
);
    // ==========================================================
    // pin sampling
    logic tck_rise;
    logic tck_fall;
    logic tms;
    logic tdi;
    logic reset_pin_n;
    logic reset_pin_rise;
    logic [2:0] int_level;
    logic tap_rst_n;

    // only the edges of the test clock are used; its level stays open
    bsd_sync #(.WIDTH(1)) u_sync_tck (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_pin(i_tck),
        .o_level(), .o_rise(tck_rise), .o_fall(tck_fall)
    );
    bsd_sync #(.WIDTH(2)) u_sync_tms_tdi (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_pin({i_tms, i_tdi}),
        .o_level({tms, tdi}), .o_rise(), .o_fall()
    );
    // same three-stage lag on both, so the reload sees levels no older
    // than the reset negation that triggers it
    bsd_sync #(.WIDTH(1)) u_sync_reset_pin (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_pin(i_reset_input_pin_n),
        .o_level(reset_pin_n), .o_rise(reset_pin_rise), .o_fall()
    );
    bsd_sync #(.WIDTH(3)) u_sync_int_level (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_pin(i_interrupt_level_pins),
        .o_level(int_level), .o_rise(), .o_fall()
    );

    // test reset acts on the controller with no clock needed
    assign tap_rst_n = i_arst_n & i_trst_n;

    // ==========================================================
    // controller
    bsd_pkg::bsd_tap_state_type state;

    bsd_tap u_tap (
        .i_clk(i_clk), .i_rst_n(tap_rst_n), .i_tck_rise(tck_rise),
        .i_tms(tms), .o_state(state)
    );

    logic cap_dr;
    logic sh_dr;
    logic upd_dr;
    assign cap_dr = tck_rise && state == bsd_pkg::CAPTURE_DR;
    assign sh_dr = tck_rise && state == bsd_pkg::SHIFT_DR;
    assign upd_dr = tck_fall && state == bsd_pkg::UPDATE_DR;

    // ==========================================================
    // instruction register
    logic [3:0] ir_shift;
    logic [3:0] ir;

    always_ff @(posedge i_clk or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            ir_shift <= bsd_pkg::INSTR_BYPASS;
            ir <= bsd_pkg::INSTR_BYPASS;
        end else if (state == bsd_pkg::TEST_LOGIC_RESET) begin
            ir <= bsd_pkg::INSTR_BYPASS;
        end else if (tck_rise && state == bsd_pkg::CAPTURE_IR) begin
            ir_shift <= bsd_pkg::IR_CAPTURE;
        end else if (tck_rise && state == bsd_pkg::SHIFT_IR) begin
            ir_shift <= {tdi, ir_shift[3:1]};
        end else if (tck_fall && state == bsd_pkg::UPDATE_IR) begin
            ir <= ir_shift;
        end
    end

    // ==========================================================
    // bypass stage
    logic bypass;

    always_ff @(posedge i_clk or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            bypass <= 1'b0;
        end else if (ir == bsd_pkg::INSTR_BYPASS && cap_dr) begin
            bypass <= 1'b0;
        end else if (ir == bsd_pkg::INSTR_BYPASS && sh_dr) begin
            bypass <= tdi;
        end
    end

    // ==========================================================
    // boundary scan chain
    logic [183:0] bsr;
    logic bsr_sel;
    assign bsr_sel = ir == bsd_pkg::INSTR_EXTEST || ir == bsd_pkg::INSTR_SAMPLE;

    // capture picks the source by cell kind; bits 0..4, the pairs and the
    // data cells all fall out of the kind function
    always_ff @(posedge i_clk or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            bsr <= '0;
        end else if (bsr_sel && cap_dr) begin
            for (int i = 0; i < bsd_pkg::BSR_LEN; i++) begin
                unique case (bsd_pkg::cell_kind(i))
                    bsd_pkg::CELL_OUT_LATCH: bsr[i] <= i_out_latch[i];
                    bsd_pkg::CELL_IN_PIN: bsr[i] <= i_pin_level[i];
                    bsd_pkg::CELL_DIR_CTL: bsr[i] <= o_bsr_drive[i];
                endcase
            end
        end else if (bsr_sel && sh_dr) begin
            bsr <= {tdi, bsr[bsd_pkg::BSR_LAST:1]};
        end
    end

    // update stage loads from the chain under extest and sample alike; pad ownership is o_test_owns_pins
    always_ff @(posedge i_clk or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            o_bsr_drive <= '0;
        end else if (bsr_sel && upd_dr) begin
            o_bsr_drive <= bsr;
        end
    end

    always_ff @(posedge i_clk or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            o_test_owns_pins <= 1'b0;
            o_gen_enable <= 1'b0;
            o_ab_enable <= 1'b0;
            o_db_enable <= 1'b0;
        end else begin
            o_test_owns_pins <= ir == bsd_pkg::INSTR_EXTEST || ir == bsd_pkg::INSTR_HIGHZ;
            // highz keeps all enables off; extest uses the direction cells
            o_gen_enable <= ir == bsd_pkg::INSTR_EXTEST
                && o_bsr_drive[bsd_pkg::GEN_CTL_BIT];
            o_ab_enable <= ir == bsd_pkg::INSTR_EXTEST
                && o_bsr_drive[bsd_pkg::AB_CTL_BIT];
            o_db_enable <= ir == bsd_pkg::INSTR_EXTEST
                && o_bsr_drive[bsd_pkg::DB_CTL_BIT];
        end
    end

    // ==========================================================
    // drive-control latches
    logic [2:0] drv_shift;
    logic [7:0] seq_count;
    logic drv_upd;

    always_ff @(posedge i_clk or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            drv_shift <= '0;
        end else if (ir == bsd_pkg::INSTR_DRIVE_CONTROL_SET && cap_dr) begin
            drv_shift <= o_drive_control;
        end else if (ir == bsd_pkg::INSTR_DRIVE_CONTROL_SET && sh_dr) begin
            drv_shift <= {tdi, drv_shift[2:1]};
        end
    end

    // internal reset sequence counts system clocks after reset release
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            seq_count <= '0;
            o_drive_set_ready <= 1'b0;
        end else if (!reset_pin_n || reset_pin_rise) begin
            seq_count <= '0;
            o_drive_set_ready <= 1'b0;
        end else if (!o_drive_set_ready) begin
            seq_count <= seq_count + 8'h01;
            o_drive_set_ready <= seq_count == bsd_pkg::RESET_SEQ_LAST;
        end
    end

    assign drv_upd = upd_dr && ir == bsd_pkg::INSTR_DRIVE_CONTROL_SET && o_drive_set_ready;

    // reset release reload wins, being the system's own configuration step
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_drive_control <= '0;
        end else if (reset_pin_rise && !o_test_owns_pins) begin
            o_drive_control <= int_level;
        end else if (drv_upd) begin
            o_drive_control <= drv_shift;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_bus_wait <= 1'b0;
        end else begin
            o_bus_wait <= drv_upd;
        end
    end

    // ==========================================================
    // serial output on test-clock falling edges
    logic tdo_bit;
    always_comb begin
        tdo_bit = bypass;
        if (state == bsd_pkg::SHIFT_IR) begin
            tdo_bit = ir_shift[0];
        end else if (bsr_sel) begin
            tdo_bit = bsr[0];
        end else if (ir == bsd_pkg::INSTR_DRIVE_CONTROL_SET) begin
            tdo_bit = drv_shift[0];
        end
    end

    always_ff @(posedge i_clk or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            o_tdo <= 1'b0;
            o_tdo_oe_n <= 1'b1;
        end else if (tck_fall) begin
            o_tdo <= tdo_bit;
            o_tdo_oe_n <= !(state == bsd_pkg::SHIFT_DR || state == bsd_pkg::SHIFT_IR);
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    bypass_zero_a: assert property (
        cap_dr && ir == bsd_pkg::INSTR_BYPASS |=> !bypass)
        else $error("bypass not cleared in capture");
    bypass_path_a: assert property (
        sh_dr && ir == bsd_pkg::INSTR_BYPASS |=> bypass == $past(tdi))
        else $error("bypass did not take serial input");
    chain_shift_a: assert property (
        sh_dr && bsr_sel |=> bsr[183] == $past(tdi) && bsr[0] == $past(bsr[1]))
        else $error("chain shift wrong");
    out_capture_a: assert property (
        cap_dr && bsr_sel |=> bsr[0] == $past(i_out_latch[0])
            && bsr[6] == $past(i_pin_level[6]))
        else $error("capture source wrong");
    drive_load_a: assert property (
        reset_pin_rise && !o_test_owns_pins |=> o_drive_control == $past(int_level))
        else $error("drive latches not loaded at reset release");
    drive_gate_a: assert property (
        reset_pin_rise |=> !o_drive_set_ready [*8])
        else $error("drive-set ready too early");
    drive_update_a: assert property (
        drv_upd && !reset_pin_rise |=> o_drive_control == $past(drv_shift) ##0 o_bus_wait)
        else $error("drive update or wait missing");
    trst_force_a: assert property (
        !i_trst_n |-> state == bsd_pkg::TEST_LOGIC_RESET)
        else $error("test reset did not force reset state");
    tdo_fall_a: assert property (
        tck_fall && state == bsd_pkg::SHIFT_DR |=> !o_tdo_oe_n && o_tdo == $past(tdo_bit))
        else $error("serial output not on falling edge");
    wait_pulse_a: assert property (
        o_bus_wait |=> !o_bus_wait)
        else $error("bus wait longer than one cycle");
    highz_off_a: assert property (
        ir == bsd_pkg::INSTR_HIGHZ && $past(ir) == bsd_pkg::INSTR_HIGHZ
            |-> !o_gen_enable && !o_ab_enable && !o_db_enable)
        else $error("enable on under high-z");
    ab_enable_a: assert property (
        ir == bsd_pkg::INSTR_EXTEST && $past(ir) == bsd_pkg::INSTR_EXTEST
            |-> o_ab_enable == $past(o_bsr_drive[bsd_pkg::AB_CTL_BIT]))
        else $error("address enable does not follow its cell");

    bypass_cov_c: cover property (cap_dr && ir == bsd_pkg::INSTR_BYPASS);
    extest_cov_c: cover property (upd_dr && ir == bsd_pkg::INSTR_EXTEST);
    drvset_cov_c: cover property (drv_upd);
    highz_cov_c: cover property (ir == bsd_pkg::INSTR_HIGHZ);
endmodule

// File: src/bsd_pkg.sv
// Purpose: shared constants and types of the boundary-scan test block
// Assumes: one system clock; test pins are sampled, never used as clocks
// Notes: instruction codes and enable-cell positions are local choices
package bsd_pkg;

    // ==========================================================
    // clocking and reset sequence
    localparam int CLK_PERIOD_NS = 20;
    localparam int RESET_SEQ_CLOCKS = 128;
    localparam logic [7:0] RESET_SEQ_LAST = 8'h7F;

    // ==========================================================
    // instruction register
    localparam int IR_WIDTH = 4;
    localparam logic [3:0] IR_CAPTURE = 4'h1;
    localparam logic [3:0] INSTR_EXTEST = 4'h0;
    localparam logic [3:0] INSTR_SAMPLE = 4'h2;
    localparam logic [3:0] INSTR_HIGHZ = 4'h4;
    localparam logic [3:0] INSTR_DRIVE_CONTROL_SET = 4'h6;
    localparam logic [3:0] INSTR_BYPASS = 4'hF;

    // ==========================================================
    // boundary scan chain layout
    localparam int BSR_LEN = 184;
    localparam int BSR_LAST = 183;
    localparam int TS_OUT_FIRST = 2;
    localparam int PAIR_FIRST = 5;
    localparam int PAIR_LAST = 52;
    localparam int DATA_FIRST = 53;
    localparam int DATA_LAST = 73;
    localparam int GEN_CTL_BIT = 180;
    localparam int AB_CTL_BIT = 181;
    localparam int DB_CTL_BIT = 182;
    localparam int DRV_WIDTH = 3;

    typedef enum logic [1:0] {
        CELL_OUT_LATCH,
        CELL_IN_PIN,
        CELL_DIR_CTL
    } bsd_cell_type;

    typedef enum logic [3:0] {
        TEST_LOGIC_RESET, RUN_TEST_IDLE,
        SELECT_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPDATE_DR,
        SELECT_IR, CAPTURE_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPDATE_IR
    } bsd_tap_state_type;

    // pairs alternate output latch (odd) and input pin (even); cells above
    // the data lines default to output latches
    function automatic bsd_cell_type cell_kind(input int idx);
        if (idx == GEN_CTL_BIT || idx == AB_CTL_BIT || idx == DB_CTL_BIT) begin
            return CELL_DIR_CTL;
        end else if (idx >= PAIR_FIRST && idx <= PAIR_LAST && idx[0] == 1'b0) begin
            return CELL_IN_PIN;
        end else begin
            return CELL_OUT_LATCH;
        end
    endfunction

endpackage

// File: src/bsd_sync.sv
// Purpose: three-stage pin synchroniser with agreement filter and edges
// Assumes: inputs are asynchronous to i_clk
// Notes: level changes only when stages two and three agree
`timescale 1ns/1ps
module bsd_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic [WIDTH-1:0] i_pin,
    output logic [WIDTH-1:0] o_level,
    output logic [WIDTH-1:0] o_rise,
    output logic [WIDTH-1:0] o_fall
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else begin
            stage1 <= i_pin;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_level <= '0;
            o_rise <= '0;
            o_fall <= '0;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                o_rise[i] <= 1'b0;
                o_fall[i] <= 1'b0;
                if (stage2[i] == stage3[i] && stage3[i] != o_level[i]) begin
                    o_level[i] <= stage3[i];
                    o_rise[i] <= stage3[i];
                    o_fall[i] <= ~stage3[i];
                end
            end
        end
    end
endmodule

// File: src/bsd_tap.sv
// Purpose: sixteen-state test access port controller
// Assumes: i_tck_rise is a one-cycle pulse per test-clock rising edge
// Notes: i_rst_n carries the test reset and forces reset without edges
`timescale 1ns/1ps
module bsd_tap (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_tck_rise,
    input wire logic i_tms,
    output bsd_pkg::bsd_tap_state_type o_state
);
    bsd_pkg::bsd_tap_state_type next_state;

    always_comb begin
        next_state = o_state;
        unique case (o_state)
            bsd_pkg::TEST_LOGIC_RESET: begin
                next_state = i_tms ? bsd_pkg::TEST_LOGIC_RESET : bsd_pkg::RUN_TEST_IDLE;
            end
            bsd_pkg::RUN_TEST_IDLE: next_state = i_tms ? bsd_pkg::SELECT_DR : o_state;
            bsd_pkg::SELECT_DR: next_state = i_tms ? bsd_pkg::SELECT_IR : bsd_pkg::CAPTURE_DR;
            bsd_pkg::CAPTURE_DR: next_state = i_tms ? bsd_pkg::EXIT1_DR : bsd_pkg::SHIFT_DR;
            bsd_pkg::SHIFT_DR: next_state = i_tms ? bsd_pkg::EXIT1_DR : o_state;
            bsd_pkg::EXIT1_DR: next_state = i_tms ? bsd_pkg::UPDATE_DR : bsd_pkg::PAUSE_DR;
            bsd_pkg::PAUSE_DR: next_state = i_tms ? bsd_pkg::EXIT2_DR : o_state;
            bsd_pkg::EXIT2_DR: next_state = i_tms ? bsd_pkg::UPDATE_DR : bsd_pkg::SHIFT_DR;
            bsd_pkg::UPDATE_DR: next_state = i_tms ? bsd_pkg::SELECT_DR : bsd_pkg::RUN_TEST_IDLE;
            bsd_pkg::SELECT_IR: begin
                next_state = i_tms ? bsd_pkg::TEST_LOGIC_RESET : bsd_pkg::CAPTURE_IR;
            end
            bsd_pkg::CAPTURE_IR: next_state = i_tms ? bsd_pkg::EXIT1_IR : bsd_pkg::SHIFT_IR;
            bsd_pkg::SHIFT_IR: next_state = i_tms ? bsd_pkg::EXIT1_IR : o_state;
            bsd_pkg::EXIT1_IR: next_state = i_tms ? bsd_pkg::UPDATE_IR : bsd_pkg::PAUSE_IR;
            bsd_pkg::PAUSE_IR: next_state = i_tms ? bsd_pkg::EXIT2_IR : o_state;
            bsd_pkg::EXIT2_IR: next_state = i_tms ? bsd_pkg::UPDATE_IR : bsd_pkg::SHIFT_IR;
            bsd_pkg::UPDATE_IR: next_state = i_tms ? bsd_pkg::SELECT_DR : bsd_pkg::RUN_TEST_IDLE;
        endcase
    end

    // mode select acts only on a test-clock rising edge
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_state <= bsd_pkg::TEST_LOGIC_RESET;
        end else if (i_tck_rise) begin
            o_state <= next_state;
        end
    end
endmodule

// File: test/bsd_tester.sv
// Purpose: board tester model that drives the test access port pins
// Assumes: test clock is made from i_clk, nine clocks a period (180 ns)
// Notes: test clock stands still between calls; unused data-in toggles
`timescale 1ns/1ps
module bsd_tester (
    input wire logic i_clk,
    input wire logic i_tdo,
    output logic o_tck,
    output logic o_tms,
    output logic o_tdi,
    output logic o_trst_n
);
    // ==========================================================
    // pin start-up
    initial begin
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_tdi = 1'b0;
        o_trst_n = 1'b0;
    end

    // ==========================================================
    // one test clock period
    // mode and data change with the fall so the device sees them settled at
    // the rise; the out bit is read late in the high phase because the
    // sampled path lags the pin by several clocks
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        @(posedge i_clk);
        o_tck <= 1'b0;
        o_tms <= tms;
        o_tdi <= tdi;
        repeat (4) @(posedge i_clk);
        o_tck <= 1'b1;
        repeat (4) @(posedge i_clk);
        #1 tdo = i_tdo;
    endtask

    task automatic move(input logic tms);
        logic unused;
        step(tms, ~o_tdi, unused);
    endtask

    // ==========================================================
    // test reset, instruction and data scans
    task automatic trst(input logic lvl);
        @(posedge i_clk);
        o_trst_n <= lvl;
        if (lvl) begin
            move(1'b0);
            move(1'b0);
        end
    endtask

    task automatic ir(input logic [3:0] code, output logic [3:0] cap);
        move(1'b1);
        move(1'b1);
        move(1'b0);
        move(1'b0);
        for (int i = 0; i < 4; i++) begin
            step(i == 3, code[i], cap[i]);
        end
        move(1'b1);
        move(1'b0);
    endtask

    task automatic dr(input int n, input logic [191:0] din, output logic [191:0] dout);
        dout = '0;
        move(1'b1);
        move(1'b0);
        move(1'b0);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], dout[i]);
        end
        move(1'b1);
        move(1'b0);
    endtask
endmodule

// File: test/bsd_top_bench.sv
// Purpose: self-checking bench of the boundary-scan block
// Assumes: tester model drives the test pins; bench drives system pins
// Notes: direction cells 180-182 are not compared on capture
`timescale 1ns/1ps
module bsd_top_bench;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic rst_pin_n = 1'b0;
    logic [2:0] int_lvl = 3'h0;
    logic [183:0] out_latch = '0;
    logic [183:0] pin_level = '0;
    logic tck, tms, tdi, trst_n, tdo, tdo_oe_n, owns, gen_en, ab_en, db_en, ready, bus_wait;
    logic [183:0] bsr_drive;
    logic [2:0] drv;
    logic [3:0] cap;
    logic [191:0] dout;
    int bad_count = 0;
    int num_checks = 0;
    int cycles = 0;
    int waits = 0;

    always #10 clk = ~clk;

    bsd_tester bsd_tester_i (.i_clk(clk), .i_tdo(tdo), .o_tck(tck), .o_tms(tms),
        .o_tdi(tdi), .o_trst_n(trst_n));

    bsd_top bsd_top_i (.i_clk(clk), .i_arst_n(arst_n), .i_tck(tck), .i_tms(tms),
        .i_tdi(tdi), .i_trst_n(trst_n), .i_reset_input_pin_n(rst_pin_n),
        .i_interrupt_level_pins(int_lvl), .i_out_latch(out_latch), .i_pin_level(pin_level),
        .o_tdo(tdo), .o_tdo_oe_n(tdo_oe_n), .o_test_owns_pins(owns), .o_bsr_drive(bsr_drive),
        .o_gen_enable(gen_en), .o_ab_enable(ab_en), .o_db_enable(db_en),
        .o_drive_control(drv), .o_drive_set_ready(ready), .o_bus_wait(bus_wait));

    // ==========================================================
    // reporting and hang guard
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask

    // bus wait pulses are counted so a missing or doubled pulse shows up
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (bus_wait === 1'b1) begin
            waits <= waits + 1;
        end
        if (cycles == 30000) begin
            bad_count++;
            end_sim();
        end
    end

    // ==========================================================
    // scenarios
    task automatic pin_release(input logic [2:0] lvl);
        @(posedge clk);
        rst_pin_n <= 1'b0;
        repeat (10) @(posedge clk);
        int_lvl <= lvl;
        rst_pin_n <= 1'b1;
        repeat (12) @(posedge clk);
        check(drv === lvl, "drive latches not loaded");
    endtask

    task automatic t_refused();
        int w;
        w = waits;
        bsd_tester_i.ir(4'h6, cap);
        check(cap === 4'h1, "instruction capture value");
        bsd_tester_i.dr(3, 192'h6, dout);
        check(ready === 1'b0 && drv === 3'h0, "drive set taken too early");
        check(waits === w, "bus wait on refused update");
    endtask

    task automatic t_ready();
        pin_release(3'h5);
        repeat (100) @(posedge clk);
        check(ready === 1'b0, "ready before internal reset done");
        repeat (30) @(posedge clk);
        check(ready === 1'b1, "ready missing after internal reset");
    endtask

    task automatic t_drive_set();
        int w;
        w = waits;
        bsd_tester_i.dr(3, 192'h3, dout);
        check(dout[2:0] === 3'h5, "drive set capture");
        check(drv === 3'h3, "drive latches not updated");
        check(waits === w + 1, "bus wait pulse count");
    endtask

    task automatic t_sample();
        logic e;
        out_latch <= {23{8'hA5}};
        pin_level <= ~{23{8'hA5}};
        bsd_tester_i.ir(4'h2, cap);
        bsd_tester_i.dr(185, 192'h1, dout);
        for (int i = 0; i < 184; i++) begin
            e = (i >= 5 && i <= 52 && i % 2 == 0) ? pin_level[i] : out_latch[i];
            if (i < 180 || i > 182) begin
                check(dout[i] === e, "captured cell value");
            end
        end
        check(dout[184] === 1'b1, "chain length");
        check(owns === 1'b0, "sample took the pins");
    endtask

    task automatic t_extest();
        logic [183:0] p;
        p = {8'h2C, {22{8'h5A}}};
        bsd_tester_i.ir(4'h0, cap);
        bsd_tester_i.dr(184, {8'h00, p}, dout);
        check(bsr_drive === p && owns === 1'b1, "drive stage after update");
        check(ab_en === 1'b1 && db_en === 1'b0 && gen_en === 1'b0, "enable cells");
        bsd_tester_i.ir(bsd_pkg::INSTR_HIGHZ, cap);
        check(owns === 1'b1 && ab_en === 1'b0 && bsr_drive === p, "high-z enables");
    endtask

    task automatic t_trst();
        bsd_tester_i.trst(1'b0);
        repeat (3) @(posedge clk);
        check(owns === 1'b0 && tdo_oe_n === 1'b1, "test reset without clock");
        check(bsr_drive === '0 && drv === 3'h2, "test reset scope");
        bsd_tester_i.trst(1'b1);
    endtask

    task automatic t_bypass();
        bsd_tester_i.dr(8, 192'hFF, dout);
        bsd_tester_i.dr(8, 192'hB3, dout);
        check(dout[0] === 1'b0, "bypass first bit");
        for (int i = 1; i < 8; i++) begin
            check(dout[i] === (8'hB3 >> (i - 1)) % 2, "bypass path length");
        end
    endtask

    // ==========================================================
    // main sequence
    initial begin
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        repeat (6) @(posedge clk);
        bsd_tester_i.trst(1'b1);
        t_refused();
        t_ready();
        t_drive_set();
        pin_release(3'h2);
        t_sample();
        t_extest();
        t_trst();
        t_bypass();
        end_sim();
    end
endmodule
